// [lane_status_pkg.sv]
// package for the lane 5 / lane 6 link status register bank
// assumes receiver inputs from another clock domain, the bank on sys_clk, and a plain strobe register port
// How it works
// - error flag set when count reaches threshold
// - bit 7 is bad disparity flag
// - bit 6 is not in table flag
// - bit 5 is unexpected control flag
// - bit 4 is interlane deskew done
// - bit 3 is initial lane sync
// - bit 2 is config checksum match
// - bit 1 is frame sync
// - bit 0 is code group sync
// - lane 5 uses lane 6 layout
package lane_status_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 8;
    localparam int NLANES = 2;
    // register offsets
    localparam logic [11:0] LANE5_STATUS_ADDR = 12'h4B5;
    localparam logic [11:0] LANE6_STATUS_ADDR = 12'h4B6;
    localparam logic [11:0] IRQ_STATUS_ADDR   = 12'h4C0;
    localparam logic [11:0] IRQ_MASK_ADDR     = 12'h4C1;
    localparam logic [11:0] THRESHOLD_ADDR    = 12'h4C2;
    localparam logic [11:0] CTRL_ADDR         = 12'h4C3;
    // status byte bit positions
    localparam int BIT_BDE = 7;
    localparam int BIT_NIT = 6;
    localparam int BIT_UEK = 5;
    localparam int BIT_ILD = 4;
    localparam int BIT_ILS = 3;
    localparam int BIT_CKS = 2;
    localparam int BIT_FS  = 1;
    localparam int BIT_CGS = 0;
    // control register bit
    localparam int BIT_BYPASS = 0;
    // reset values
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'hFF;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
endpackage

// [lane_status_cell.sv]
// one lane's status byte: threshold compares and sync status bits
// assumes error counts and sync levels already in the sys_clk domain
module lane_status_cell
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // threshold
    input  wire logic [7:0]  threshold,
    // counts and levels from the receiver
    input  wire logic [7:0]  disparityCount,
    input  wire logic [7:0]  notInTableCount,
    input  wire logic [7:0]  unexpectedCount,
    input  wire logic        deskewDone,
    input  wire logic        initialLaneSync,
    input  wire logic        configSumMatch,
    input  wire logic        frameSync,
    input  wire logic        codeGroupSync,
    // status byte
    output logic      [7:0]  status
);
    logic [7:0] next_status;

    // assemble the status byte
    always_comb
    begin
        next_status = lane_status_pkg::STATUS_RESET;
        next_status[lane_status_pkg::BIT_BDE] = disparityCount >= threshold;
        next_status[lane_status_pkg::BIT_NIT] = notInTableCount >= threshold;
        next_status[lane_status_pkg::BIT_UEK] = unexpectedCount >= threshold;
        next_status[lane_status_pkg::BIT_ILD] = deskewDone;
        next_status[lane_status_pkg::BIT_ILS] = initialLaneSync;
        next_status[lane_status_pkg::BIT_CKS] = configSumMatch;
        next_status[lane_status_pkg::BIT_FS]  = frameSync;
        next_status[lane_status_pkg::BIT_CGS] = codeGroupSync;
    end

    // register the byte, clear on reset
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            status <= lane_status_pkg::STATUS_RESET;
        else
            status <= next_status;
    end

    // flag follows threshold compare one cycle later
    bad_disp_a: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 status[lane_status_pkg::BIT_BDE] == $past(disparityCount >= threshold))
        else $error("bad disparity flag wrong");
    nit_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 status[lane_status_pkg::BIT_NIT] == $past(notInTableCount >= threshold))
        else $error("not in table flag wrong");
    uek_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 status[lane_status_pkg::BIT_UEK] == $past(unexpectedCount >= threshold))
        else $error("unexpected control flag wrong");
    below_thresh_a: assert property (@(posedge sys_clk) disable iff (srst)
        (disparityCount < threshold) |=> !status[lane_status_pkg::BIT_BDE])
        else $error("flag set below threshold");
    sync_bits_a: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 status[4:0] == $past({deskewDone, initialLaneSync, configSumMatch,
                                  frameSync, codeGroupSync}))
        else $error("sync bits wrong");
    reset_clear_a: assert property (@(posedge sys_clk)
        srst |=> status == lane_status_pkg::STATUS_RESET)
        else $error("status not cleared by reset");
endmodule

// [serial_lane_link_status.sv]
// top of the lane 5 / lane 6 link status register bank
// assumes lane status inputs arrive from another clock domain (pins)
// and a register master on sys_clk with one-cycle strobes
//
// The implementer's own choice: the address-and-strobe port.
module serial_lane_link_status
#(
    parameter int NLANES = lane_status_pkg::NLANES
)
(
    // clock and reset
    input  wire logic                                 sys_clk,
    input  wire logic                                 srst,
    // register port
    input  wire logic [lane_status_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [lane_status_pkg::DATA_W-1:0]   regWrData,
    input  wire logic                                 regWrite,
    input  wire logic                                 regRead,
    output logic      [lane_status_pkg::DATA_W-1:0]   regRdData,
    // per-lane receiver state, index 0 is lane 5, index 1 is lane 6
    input  wire logic [NLANES-1:0][7:0]               disparityCount,
    input  wire logic [NLANES-1:0][7:0]               notInTableCount,
    input  wire logic [NLANES-1:0][7:0]               unexpectedCount,
    input  wire logic [NLANES-1:0]                    deskewDone,
    input  wire logic [NLANES-1:0]                    initialLaneSync,
    input  wire logic [NLANES-1:0]                    configSumMatch,
    input  wire logic [NLANES-1:0]                    frameSync,
    input  wire logic [NLANES-1:0]                    codeGroupSync,
    // interrupt
    output logic                                      irq
);
    localparam int W = 3 * 8 + 5;

    logic [7:0]                   error_count_threshold;
    logic                         alignment_sequence_bypass;
    logic [NLANES-1:0][W-1:0]     syncStage1;
    logic [NLANES-1:0][W-1:0]     syncStage2;
    logic [NLANES-1:0][7:0]       laneStatus;
    logic [NLANES-1:0][7:0]       prevStatus;
    logic [NLANES-1:0]            laneEvent;
    logic [NLANES-1:0]            irqStatus;
    logic [NLANES-1:0]            irqMask;
    logic [lane_status_pkg::DATA_W-1:0] next_rdData;

    // two-flop synchronisers on all receiver inputs
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            syncStage1 <= '0;
            syncStage2 <= '0;
        end
        else
        begin
            for (int i = 0; i < NLANES; i++)
            begin
                syncStage1[i] <= {disparityCount[i], notInTableCount[i], unexpectedCount[i],
                                  deskewDone[i], initialLaneSync[i], configSumMatch[i],
                                  frameSync[i], codeGroupSync[i]};
            end
            syncStage2 <= syncStage1;
        end
    end

    // one status cell per lane, same layout for both
    generate
        for (genvar g = 0; g < NLANES; g++)
        begin : g_lane
            lane_status_cell u_cell
            (
                .sys_clk         (sys_clk),
                .srst            (srst),
                .threshold       (error_count_threshold),
                .disparityCount  (syncStage2[g][28:21]),
                .notInTableCount (syncStage2[g][20:13]),
                .unexpectedCount (syncStage2[g][12:5]),
                .deskewDone      (syncStage2[g][4]),
                .initialLaneSync (syncStage2[g][3]),
                .configSumMatch  (syncStage2[g][2]),
                .frameSync       (syncStage2[g][1]),
                .codeGroupSync   (syncStage2[g][0]),
                .status          (laneStatus[g])
            );
            // event: an error flag rises or a sync bit falls
            assign laneEvent[g] = |(laneStatus[g][7:5] & ~prevStatus[g][7:5])
                                | |(~laneStatus[g][4:0] & prevStatus[g][4:0]);
        end
    endgenerate

    // previous status for edge detection
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            prevStatus <= '0;
        else
            prevStatus <= laneStatus;
    end

    // threshold and bypass control, writable
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            error_count_threshold     <= lane_status_pkg::THRESHOLD_RESET;
            alignment_sequence_bypass <= 1'b0;
        end
        else if (regWrite)
        begin
            if (regAddr == lane_status_pkg::THRESHOLD_ADDR)
                error_count_threshold <= regWrData;
            if (regAddr == lane_status_pkg::CTRL_ADDR)
                alignment_sequence_bypass <= regWrData[lane_status_pkg::BIT_BYPASS];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            irqStatus <= '0;
            irqMask   <= '0;
        end
        else
        begin
            if (regWrite && regAddr == lane_status_pkg::IRQ_STATUS_ADDR)
                irqStatus <= (irqStatus & ~regWrData[NLANES-1:0]) | laneEvent;
            else
                irqStatus <= irqStatus | laneEvent;
            if (regWrite && regAddr == lane_status_pkg::IRQ_MASK_ADDR)
                irqMask <= regWrData[NLANES-1:0];
        end
    end

    assign irq = |(irqStatus & irqMask);

    // read mux; status registers ignore writes
    always_comb
    begin
        next_rdData = lane_status_pkg::ZERO_BYTE;
        case (regAddr)
            lane_status_pkg::LANE5_STATUS_ADDR: next_rdData = laneStatus[0];
            lane_status_pkg::LANE6_STATUS_ADDR: next_rdData = laneStatus[1];
            lane_status_pkg::IRQ_STATUS_ADDR:   next_rdData[NLANES-1:0] = irqStatus;
            lane_status_pkg::IRQ_MASK_ADDR:     next_rdData[NLANES-1:0] = irqMask;
            lane_status_pkg::THRESHOLD_ADDR:    next_rdData = error_count_threshold;
            lane_status_pkg::CTRL_ADDR:
                next_rdData[lane_status_pkg::BIT_BYPASS] = alignment_sequence_bypass;
            default:                            next_rdData = lane_status_pkg::ZERO_BYTE;
        endcase
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            regRdData <= lane_status_pkg::ZERO_BYTE;
        else if (regRead)
            regRdData <= next_rdData;
        else
            regRdData <= lane_status_pkg::ZERO_BYTE;
    end

    rd_lane6_a: assert property (@(posedge sys_clk) disable iff (srst)
        regRead && regAddr == lane_status_pkg::LANE6_STATUS_ADDR
        |=> regRdData == $past(laneStatus[1]))
        else $error("lane 6 read wrong");
    rd_lane5_a: assert property (@(posedge sys_clk) disable iff (srst)
        regRead && regAddr == lane_status_pkg::LANE5_STATUS_ADDR
        |=> regRdData == $past(laneStatus[0]))
        else $error("lane 5 read wrong");
    status_nowrite_a: assert property (@(posedge sys_clk) disable iff (srst)
        regWrite && regAddr == lane_status_pkg::LANE6_STATUS_ADDR
        |=> $stable(error_count_threshold) && $stable(irqMask))
        else $error("status write had an effect");
    irq_sticky_a: assert property (@(posedge sys_clk) disable iff (srst)
        laneEvent[0] |=> irqStatus[0])
        else $error("event lost");
    lane5_flag_c: cover property (@(posedge sys_clk) laneStatus[0][7]);
    lane6_sync_c: cover property (@(posedge sys_clk) laneStatus[1][4:0] == 5'h1F);
    irq_c:        cover property (@(posedge sys_clk) irq);
endmodule

// [lane_link_partner.sv]
// far-side transmitter model: drives per-lane error counts and sync levels
// assumes the bench calls drive() from its own process, with a lag in cycles
module lane_link_partner
(
    // clock
    input  wire logic             sys_clk,
    // per-lane receiver view of the link
    output logic      [1:0][7:0]  disparityCount,
    output logic      [1:0][7:0]  notInTableCount,
    output logic      [1:0][7:0]  unexpectedCount,
    output logic      [1:0]       deskewDone,
    output logic      [1:0]       initialLaneSync,
    output logic      [1:0]       configSumMatch,
    output logic      [1:0]       frameSync,
    output logic      [1:0]       codeGroupSync
);
    timeunit 1ns;
    timeprecision 1ps;
    // link starts unsynchronised with clean counters
    initial
    begin
        disparityCount  = '0;
        notInTableCount = '0;
        unexpectedCount = '0;
        {deskewDone, initialLaneSync, configSumMatch, frameSync, codeGroupSync} = '0;
    end
    // apply one lane's counts and levels after lag + 1 cycles
    task automatic drive(input int lane, input int lag, input logic [7:0] d, n, u,
                         input logic [4:0] s);
        repeat (lag + 1) @(posedge sys_clk);
        disparityCount[lane]  <= d;
        notInTableCount[lane] <= n;
        unexpectedCount[lane] <= u;
        {deskewDone[lane], initialLaneSync[lane], configSumMatch[lane]} <= s[4:2];
        {frameSync[lane], codeGroupSync[lane]} <= s[1:0];
    endtask
endmodule

// [serial_lane_link_status_bench.sv]
// self-checking bench for the lane 5 / lane 6 link status bank
// assumes the partner model feeds the lane inputs; bench owns the register port
module serial_lane_link_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic             sys_clk, srst, regWrite, regRead, irq;
    logic [11:0]      regAddr;
    logic [7:0]       regWrData, regRdData;
    logic [1:0][7:0]  disparityCount, notInTableCount, unexpectedCount;
    logic [1:0]       deskewDone, initialLaneSync, configSumMatch, frameSync, codeGroupSync;
    int               errCount, totalChecks, cycles;
    // design and far side
    serial_lane_link_status #(.NLANES(2)) dut (.sys_clk(sys_clk), .srst(srst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .disparityCount(disparityCount),
        .notInTableCount(notInTableCount), .unexpectedCount(unexpectedCount),
        .deskewDone(deskewDone), .initialLaneSync(initialLaneSync),
        .configSumMatch(configSumMatch), .frameSync(frameSync),
        .codeGroupSync(codeGroupSync), .irq(irq));
    lane_link_partner far (.sys_clk(sys_clk), .disparityCount(disparityCount),
        .notInTableCount(notInTableCount), .unexpectedCount(unexpectedCount),
        .deskewDone(deskewDone), .initialLaneSync(initialLaneSync),
        .configSumMatch(configSumMatch), .frameSync(frameSync),
        .codeGroupSync(codeGroupSync));
    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic endSim();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errCount++;
            endSim();
        end
    end
    task automatic check(input string name, input logic [7:0] exp, got);
        totalChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask
    // read strobe, then sample the data in the single cycle that it stands
    task automatic rd(input string name, input logic [11:0] a, input logic [7:0] m, exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check(name, exp & m, regRdData & m);
    endtask
    // reset values, read-only status, unmapped read
    task automatic testReset();
        rd("lane5", lane_status_pkg::LANE5_STATUS_ADDR, 8'hFF, 8'h00);
        rd("lane6", lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF, 8'h00);
        rd("thresh", lane_status_pkg::THRESHOLD_ADDR, 8'hFF, 8'hFF);
        rd("mask", lane_status_pkg::IRQ_MASK_ADDR, 8'hFF, 8'h00);
        rd("unmapped", 12'h7FF, 8'hFF, 8'h00);
        wr(lane_status_pkg::LANE5_STATUS_ADDR, 8'hFF);
        wr(lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF);
        rd("lane5 wr", lane_status_pkg::LANE5_STATUS_ADDR, 8'hFF, 8'h00);
        rd("lane6 wr", lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF, 8'h00);
        check("irq", 8'(1'b0), 8'(irq));
    endtask
    // walk one sync level at a time on both lanes, slow partner on lane 6
    task automatic testSync();
        for (int i = 0; i < 5; i++)
        begin
            far.drive(0, 0, 8'h00, 8'h00, 8'h00, 5'(1 << i));
            far.drive(1, 3, 8'h00, 8'h00, 8'h00, 5'(1 << i));
            repeat (4) @(posedge sys_clk);
            rd("lane5 sync", lane_status_pkg::LANE5_STATUS_ADDR, 8'hFF, 8'(1 << i));
            rd("lane6 sync", lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF, 8'(1 << i));
        end
        far.drive(0, 0, 8'h00, 8'h00, 8'h00, 5'h00);
        far.drive(1, 0, 8'h00, 8'h00, 8'h00, 5'h00);
        repeat (4) @(posedge sys_clk);
        rd("irq sync", lane_status_pkg::IRQ_STATUS_ADDR, 8'h03, 8'h03);
        wr(lane_status_pkg::IRQ_STATUS_ADDR, 8'h03);
        rd("irq clr", lane_status_pkg::IRQ_STATUS_ADDR, 8'h03, 8'h00);
    endtask
    // each error count one below and at the threshold on lane 6
    task automatic testThreshold();
        logic [2:0][7:0] c;
        c = '0;
        wr(lane_status_pkg::THRESHOLD_ADDR, 8'h10);
        for (int k = 0; k < 3; k++)
            for (int j = 0; j < 2; j++)
            begin
                c[k] = 8'h0F + 8'(j);
                far.drive(1, 0, c[0], c[1], c[2], 5'h00);
                repeat (4) @(posedge sys_clk);
                rd("lane6 err", lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF,
                   {c[0] >= 8'h10, c[1] >= 8'h10, c[2] >= 8'h10, 5'b0});
            end
    endtask
    // sticky event bit, mask, write-one-to-clear
    task automatic testIrq();
        rd("irq stat", lane_status_pkg::IRQ_STATUS_ADDR, 8'h03, 8'h02);
        check("irq masked", 8'(1'b0), 8'(irq));
        wr(lane_status_pkg::IRQ_MASK_ADDR, 8'h02);
        check("irq on", 8'(1'b1), 8'(irq));
        wr(lane_status_pkg::IRQ_STATUS_ADDR, 8'h02);
        check("irq off", 8'(1'b0), 8'(irq));
        rd("irq stat clr", lane_status_pkg::IRQ_STATUS_ADDR, 8'h03, 8'h00);
    endtask
    // bypass set and read back; lane 6 read masks out deskew, lane sync, checksum and frame sync bits
    task automatic testBypass();
        wr(lane_status_pkg::CTRL_ADDR, 8'h01);
        rd("bypass", lane_status_pkg::CTRL_ADDR, 8'h01, 8'h01);
        rd("lane6 bypass", lane_status_pkg::LANE6_STATUS_ADDR, 8'hE1, 8'hE0);
    endtask
    // mid-run reset with live sync levels: status, control and irq clear, then resume
    task automatic testMidReset();
        far.drive(1, 0, 8'h10, 8'h10, 8'h10, 5'h1F);
        repeat (4) @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        rd("lane6 rst", lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF, 8'h00);
        rd("ctrl rst", lane_status_pkg::CTRL_ADDR, 8'hFF, 8'h00);
        rd("thresh rst", lane_status_pkg::THRESHOLD_ADDR, 8'hFF, 8'hFF);
        check("irq rst", 8'(1'b0), 8'(irq));
        repeat (4) @(posedge sys_clk);
        rd("lane6 resume", lane_status_pkg::LANE6_STATUS_ADDR, 8'hFF, 8'h1F);
    endtask
    // reset, then scenarios in order
    initial
    begin
        srst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWrite = 1'b0;
        regRead = 1'b0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        testReset();
        testSync();
        testThreshold();
        testIrq();
        testBypass();
        testMidReset();
        endSim();
    end
endmodule
